// [hw/pscfg_pkg.sv]
// package with offsets, field positions, reset values and timing for the config register bank
package pscfg_pkg;
  // clock and switch sampling timing
  localparam int              CLK_MHZ          = 100;
  localparam int              SAMPLE_PERIOD_US = 1000;
  localparam int              SAMPLE_CYCLES    = SAMPLE_PERIOD_US * CLK_MHZ;
  localparam int              TICK_W           = 17;
  localparam logic [2:0]      STABLE_SAMPLES   = 3'h4;
  // switch vector layout: config bank in 9..0, address bank in 17..10
  localparam int              SW_W             = 18;
  localparam int              ADDR_LSB         = 10;
  localparam int              SRC_BIT          = 8;
  localparam int              UNUSED_BIT       = 9;
  localparam logic [17:0]     SW_MASK          = 18'h3FDFF;
  // protocol function codes
  localparam logic [7:0]      FC_READ_HOLD     = 8'h03;
  localparam logic [7:0]      FC_READ_INPUT    = 8'h04;
  localparam logic [7:0]      FC_WRITE_SINGLE  = 8'h06;
  // register offsets
  localparam logic [15:0]     OFS_NODE_ADDR    = 16'h0000;
  localparam logic [15:0]     OFS_FRAMING      = 16'h0001;
  localparam logic [15:0]     OFS_MANUAL_ZERO  = 16'h01FB;
  localparam logic [15:0]     OFS_SERIAL       = 16'h0000;
  localparam logic [15:0]     OFS_FIRMWARE     = 16'h0008;
  localparam logic [15:0]     OFS_SENSOR_NAME  = 16'h0009;
  localparam logic [15:0]     TEXT_WORDS       = 16'h0008;
  localparam logic [15:0]     OFS_STATUS       = 16'h0259;
  localparam logic [15:0]     OFS_FLOAT        = 16'h04BA;
  localparam logic [15:0]     OFS_INT          = 16'h1009;
  localparam int              MEAS_CH          = 5;
  localparam logic [2:0]      MEAS_CH_W        = 3'h5;
  localparam int              PA_CH            = 2;
  // reset values
  localparam logic [7:0]      NODE_ADDR_RST    = 8'h2C;
  localparam logic [15:0]     FRAMING_RST      = 16'h0008;
  // framing word fields
  localparam int              FR_BAUD_LSB      = 0;
  localparam int              FR_PAR_LSB       = 3;
  localparam int              FR_STOP_BIT      = 5;
  localparam logic [1:0]      PAR_NONE         = 2'h0;
  localparam logic [1:0]      PAR_ODD          = 2'h2;
  localparam logic [2:0]      MB_BAUD_MAX      = 3'h2;
  localparam logic [2:0]      BN_BAUD_MAX      = 3'h4;
  localparam logic [7:0]      MB_ADDR_MIN      = 8'h01;
  localparam logic [7:0]      MB_ADDR_MAX      = 8'hF7;
  localparam logic [7:0]      BN_ADDR_MAX      = 8'h7F;
  // status word bit positions
  localparam int              ST_UNDER         = 0;
  localparam int              ST_OVER          = 1;
  localparam int              ST_SRC           = 2;
  localparam int              ST_ADDR_SW       = 3;
  // range limits in Pa and filter times in ms, indexed by selection code
  localparam logic signed [23:0] RANGE_LO [4] = '{-24'sd100, -24'sd50, -24'sd25, 24'sd0};
  localparam logic signed [23:0] RANGE_HI [4] = '{24'sd100, 24'sd50, 24'sd25, 24'sd100};
  localparam logic signed [23:0] RANGE_SPAN [4] = '{24'sd200, 24'sd100, 24'sd50, 24'sd100};
  localparam logic signed [23:0] SPAN_DIV = 24'sd20;
  localparam logic [12:0]     FILTER_MS [4] = '{13'h0032, 13'h01F4, 13'h07D0, 13'h0FA0};
endpackage : pscfg_pkg

// [hw/pscfg_regs.sv]
// configuration switch decode and protocol register bank of the pressure transmitter
// Operation
// - range switches select +-100, +-50, +-25 Pa or 0..100 Pa
// - response switches select 50 ms, 500 ms, 2 s or 4 s filter
// - unit switches select Pa, mbar, inch WC or kPa display
// - backlight on when its switch is zero, off when one
// - span switch picks 0-10 V with 4-20 mA or 0-5 V with 0-20 mA
// - settings source switch picks switch bank or stored software settings
// - tenth configuration switch is ignored
// - all switches zero give the factory default configuration
// - flag under-range below low minus 5 % span, overload above 105 %
// - address switches all zero use stored address, default 44
// - nonzero address switches override default and software address
// - address switches read as unsigned binary, last switch least significant
// - BACnet mode: 8N1, baud index up to 76800, address 0..127
// - Modbus mode: 8 bits, three bauds, parity, 1 or 2 stops, address 1..247
// - single write to 0x00 sets address, to 0x01 sets framing
// - single write to 0x1FB raises a manual zeroing request
// - each measurement readable as two-word float and one-word integer
// - serial number text answers at read addresses 0x00..0x07
// - firmware version at 0x08, major high byte, minor low byte
// - sensor name from 0x09; identification answers functions 0x03 and 0x04
// - status word at 0x259, readable with 0x03 or 0x04
// - address write is refused while the switches set the address
// - integer registers hold value times the per-unit scale factor
`timescale 1ns/1ps
module pscfg_regs
  import pscfg_pkg::*;
#(
  parameter int            SAMPLE_CYC  = SAMPLE_CYCLES,
  parameter logic [127:0]  SERIAL_TEXT = 128'h30303030303030303030303030303031, // arbitrary
  parameter logic [15:0]   FW_VERSION  = 16'h0100,                               // arbitrary
  parameter logic [127:0]  SENSOR_NAME = 128'h50524553535552452053454E534F5220  // arbitrary
) (
  input  wire logic              sys_clk,
  input  wire logic              reset,
  input  wire logic              range_sel_bit0,
  input  wire logic              range_sel_bit1,
  input  wire logic              response_sel_bit0,
  input  wire logic              response_sel_bit1,
  input  wire logic              unit_sel_bit0,
  input  wire logic              unit_sel_bit1,
  input  wire logic              backlight_off_sw,
  input  wire logic              output_span_sw,
  input  wire logic              settings_source_sw,
  input  wire logic              unused_switch,
  input  wire logic [7:0]        addr_switches,
  input  wire logic [1:0]        nv_range,
  input  wire logic [1:0]        nv_response,
  input  wire logic [1:0]        nv_unit,
  input  wire logic              nv_backlight_off,
  input  wire logic              nv_output_span,
  input  wire logic              proto_bacnet,
  input  wire logic              tool_addr_wr,
  input  wire logic [7:0]        tool_addr_data,
  input  wire logic              req_valid,
  input  wire logic              req_write,
  input  wire logic [7:0]        req_func,
  input  wire logic [15:0]       req_addr,
  input  wire logic [15:0]       req_wdata,
  output logic                   resp_valid,
  output logic                   resp_nak,
  output logic [15:0]            resp_data,
  input  wire logic              meas_valid,
  input  wire logic [4:0][31:0]  meas_float,
  input  wire logic [4:0][15:0]  meas_int,
  output logic [1:0]             range_code,
  output logic [12:0]            filter_time_ms,
  output logic [1:0]             unit_code,
  output logic                   backlight_on,
  output logic                   output_span_alt,
  output logic                   under_range,
  output logic                   overload,
  output logic [7:0]             node_address,
  output logic [2:0]             baud_index,
  output logic [1:0]             parity_mode,
  output logic                   two_stop_bits,
  output logic                   zero_req
);

  typedef struct packed {
    logic [SW_W-1:0]    sync1;
    logic [SW_W-1:0]    sync2;
    logic [SW_W-1:0]    sample;
    logic [SW_W-1:0]    stable;
    logic [TICK_W-1:0]  tick_cnt;
    logic [2:0]         same_cnt;
    logic [7:0]         stored_addr;
    logic [15:0]        framing;
    logic [4:0][31:0]   float_snap;
    logic [4:0][15:0]   int_snap;
    logic               under;
    logic               over;
    logic               zero;
    logic               rvalid;
    logic               rnak;
    logic [15:0]        rdata;
  } pscfg_state_s;

  pscfg_state_s       s;
  pscfg_state_s       n;
  logic               tick;
  logic               src_nv;
  logic [7:0]         sw_addr;
  logic               addr_from_sw;
  logic [1:0]         eff_range;
  logic [1:0]         eff_resp;
  logic               eff_bl_off;
  logic signed [23:0] p20;
  logic signed [23:0] lo20;
  logic signed [23:0] hi20;
  logic [15:0]        roff;
  logic [15:0]        foff;
  logic [15:0]        ioff;
  logic [15:0]        noff;
  logic               is_read;
  logic               is_wr;
  logic               addr_ok;
  logic               fr_ok;
  logic [15:0]        status_word;

  // effective settings: stored values take over when the source switch selects software
  always_comb begin
    src_nv       = s.stable[SRC_BIT];
    eff_range    = src_nv ? nv_range : s.stable[1:0];
    eff_resp     = src_nv ? nv_response : s.stable[3:2];
    eff_bl_off   = src_nv ? nv_backlight_off : s.stable[6];
    sw_addr      = s.stable[ADDR_LSB +: 8];
    addr_from_sw = (sw_addr != 8'h00);
    tick         = (s.tick_cnt == TICK_W'(SAMPLE_CYC - 1));
  end

  // decoded outputs; zero switches map to the first entry of each table
  assign range_code      = eff_range;
  assign filter_time_ms  = FILTER_MS[eff_resp];
  assign unit_code       = src_nv ? nv_unit : s.stable[5:4];
  assign backlight_on    = ~eff_bl_off;
  assign output_span_alt = src_nv ? nv_output_span : s.stable[7];
  assign node_address    = addr_from_sw ? sw_addr : s.stored_addr;
  assign baud_index      = s.framing[FR_BAUD_LSB +: 3];
  assign parity_mode     = s.framing[FR_PAR_LSB +: 2];
  assign two_stop_bits   = s.framing[FR_STOP_BIT];
  assign under_range     = s.under;
  assign overload        = s.over;
  assign zero_req        = s.zero;
  assign resp_valid      = s.rvalid;
  assign resp_nak        = s.rnak;
  assign resp_data       = s.rdata;

  // request decode helpers and limit arithmetic, times twenty so 5 % of span is whole
  always_comb begin
    p20   = $signed({{8{s.int_snap[PA_CH][15]}}, s.int_snap[PA_CH]}) * SPAN_DIV;
    lo20  = RANGE_LO[eff_range] * SPAN_DIV - RANGE_SPAN[eff_range];
    hi20  = RANGE_HI[eff_range] * SPAN_DIV + RANGE_SPAN[eff_range];
    roff  = req_addr - OFS_SERIAL;
    foff  = req_addr - OFS_FLOAT;
    ioff  = req_addr - OFS_INT;
    noff  = req_addr - OFS_SENSOR_NAME;
    is_read = req_valid && !req_write &&
              (req_func == FC_READ_HOLD || req_func == FC_READ_INPUT);
    is_wr   = req_valid && req_write && (req_func == FC_WRITE_SINGLE);
    if (proto_bacnet) begin
      addr_ok = (req_wdata[15:8] == 8'h00) && (req_wdata[7:0] <= BN_ADDR_MAX);
      fr_ok   = (req_wdata[FR_BAUD_LSB +: 3] <= BN_BAUD_MAX) &&
                (req_wdata[FR_PAR_LSB +: 2] == PAR_NONE) && !req_wdata[FR_STOP_BIT];
    end else begin
      addr_ok = (req_wdata[15:8] == 8'h00) && (req_wdata[7:0] >= MB_ADDR_MIN) &&
                (req_wdata[7:0] <= MB_ADDR_MAX);
      fr_ok   = (req_wdata[FR_BAUD_LSB +: 3] <= MB_BAUD_MAX) &&
                (req_wdata[FR_PAR_LSB +: 2] <= PAR_ODD);
    end
    status_word = 16'h0000;
    status_word[ST_UNDER]   = s.under;
    status_word[ST_OVER]    = s.over;
    status_word[ST_SRC]     = src_nv;
    status_word[ST_ADDR_SW] = addr_from_sw;
  end

  // next state of the whole block
  always_comb begin
    n        = s;
    n.zero   = 1'b0;
    n.rvalid = 1'b0;
    n.rnak   = 1'b0;
    // two-flop synchroniser on all switches
    n.sync1 = {addr_switches, unused_switch, settings_source_sw, output_span_sw,
               backlight_off_sw, unit_sel_bit1, unit_sel_bit0, response_sel_bit1,
               response_sel_bit0, range_sel_bit1, range_sel_bit0};
    n.sync2 = s.sync1;
    // sample divider and stability filter; the unused switch is masked off
    n.tick_cnt = tick ? '0 : s.tick_cnt + 1'b1;
    if (tick) begin
      n.sample = s.sync2 & SW_MASK;
      if ((s.sync2 & SW_MASK) != s.sample) begin
        n.same_cnt = 3'h0;
      end else if (s.same_cnt == STABLE_SAMPLES - 3'h1) begin
        n.stable = s.sample;
      end else begin
        n.same_cnt = s.same_cnt + 3'h1;
      end
    end
    // one snapshot per sample keeps float halves and integers coherent
    if (meas_valid) begin
      n.float_snap = meas_float;
      n.int_snap   = meas_int;
    end
    n.under = (p20 < lo20);
    n.over  = (p20 > hi20);
    // configuration tool writes the stored address
    if (tool_addr_wr) begin
      n.stored_addr = tool_addr_data;
    end
    // protocol requests: answer one cycle after each request
    if (req_valid) begin
      n.rvalid = 1'b1;
      n.rnak   = 1'b1;
      n.rdata  = 16'h0000;
    end
    if (is_read) begin
      n.rnak = 1'b0;
      if (roff < TEXT_WORDS) begin
        n.rdata = SERIAL_TEXT[16 * (7 - int'(roff[2:0])) +: 16];
      end else if (req_addr == OFS_FIRMWARE) begin
        n.rdata = FW_VERSION;
      end else if (noff < TEXT_WORDS) begin
        n.rdata = SENSOR_NAME[16 * (7 - int'(noff[2:0])) +: 16];
      end else if (req_addr == OFS_STATUS) begin
        n.rdata = status_word;
      end else if (foff < 16'(2 * MEAS_CH)) begin
        n.rdata = foff[0] ? s.float_snap[foff[3:1]][31:16]
                          : s.float_snap[foff[3:1]][15:0];
      end else if (ioff < 16'(MEAS_CH)) begin
        n.rdata = s.int_snap[ioff[2:0]];
      end else begin
        n.rnak = 1'b1;
      end
    end
    if (is_wr) begin
      if (req_addr == OFS_NODE_ADDR) begin
        if (!addr_from_sw && addr_ok) begin
          n.stored_addr = req_wdata[7:0];
          n.rnak        = 1'b0;
        end
      end else if (req_addr == OFS_FRAMING) begin
        if (fr_ok) begin
          n.framing = req_wdata;
          n.rnak    = 1'b0;
        end
      end else if (req_addr == OFS_MANUAL_ZERO) begin
        n.zero = 1'b1;
        n.rnak = 1'b0;
      end
    end
  end

  // state register
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s             <= '0;
      s.stored_addr <= NODE_ADDR_RST;
      s.framing     <= FRAMING_RST;
    end else begin
      s <= n;
    end
  end

  // checks
  property p_resp;
    @(posedge sys_clk) disable iff (reset) req_valid |=> resp_valid;
  endproperty
  a_resp: assert property (p_resp) else $error("request not answered");

  property p_zero;
    @(posedge sys_clk) disable iff (reset)
      is_wr && req_addr == OFS_MANUAL_ZERO |=> zero_req && !resp_nak
        ##1 (!zero_req || $past(is_wr && req_addr == OFS_MANUAL_ZERO));
  endproperty
  a_zero: assert property (p_zero) else $error("zeroing request missing");

  property p_nak_sw;
    @(posedge sys_clk) disable iff (reset)
      is_wr && req_addr == OFS_NODE_ADDR && addr_from_sw && !tool_addr_wr
      |=> resp_nak && $stable(s.stored_addr);
  endproperty
  a_nak_sw: assert property (p_nak_sw) else $error("address write not refused");

  property p_store;
    @(posedge sys_clk) disable iff (reset)
      is_wr && req_addr == OFS_NODE_ADDR && !addr_from_sw && addr_ok && !tool_addr_wr
      |=> addr_from_sw || node_address == $past(req_wdata[7:0]);
  endproperty
  a_store: assert property (p_store) else $error("address write lost");

  property p_override;
    @(posedge sys_clk) disable iff (reset)
      sw_addr != 8'h00 |-> node_address == s.stable[ADDR_LSB +: 8];
  endproperty
  a_override: assert property (p_override) else $error("switch address not used");

  property p_filter;
    @(posedge sys_clk) disable iff (reset)
      !src_nv && s.stable[3:2] == 2'h0 |-> filter_time_ms == 13'h0032;
  endproperty
  a_filter: assert property (p_filter) else $error("default filter wrong");

  property p_source;
    @(posedge sys_clk) disable iff (reset)
      src_nv |-> backlight_on == !nv_backlight_off && range_code == nv_range;
  endproperty
  a_source: assert property (p_source) else $error("stored settings not applied");

  property p_flags;
    @(posedge sys_clk) disable iff (reset) !(under_range && overload);
  endproperty
  a_flags: assert property (p_flags) else $error("both range flags set");

  property p_firmware;
    @(posedge sys_clk) disable iff (reset)
      is_read && req_addr == OFS_FIRMWARE |=> resp_data == FW_VERSION && !resp_nak;
  endproperty
  a_firmware: assert property (p_firmware) else $error("firmware word wrong");

  property p_debounce;
    @(posedge sys_clk) disable iff (reset) $changed(s.stable) |-> $past(tick);
  endproperty
  a_debounce: assert property (p_debounce) else $error("setting changed off a sample");

  property p_unused;
    @(posedge sys_clk) disable iff (reset) !s.stable[UNUSED_BIT];
  endproperty
  a_unused: assert property (p_unused) else $error("unused switch reached settings");

endmodule : pscfg_regs

// [verification/pscfg_master.sv]
// fieldbus master model that issues register requests to the config bank
`timescale 1ns/1ps
module pscfg_master (
  input  wire logic        sys_clk,
  input  wire logic        resp_valid,
  output logic             req_valid,
  output logic             req_write,
  output logic [7:0]       req_func,
  output logic [15:0]      req_addr,
  output logic [15:0]      req_wdata
);
  // bus idle at time zero, nothing requested before reset lifts
  initial begin
    req_valid = 1'b0;
    req_write = 1'b0;
    req_func  = 8'h00;
    req_addr  = 16'h0000;
    req_wdata = 16'h0000;
  end

  // one request per cycle, n words back to back from one start address
  task automatic xfer(input logic wr, input logic [7:0] fn, input logic [15:0] ad,
                      input logic [15:0] wd, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      #1;
      req_valid = 1'b1;
      req_write = wr;
      req_func  = fn;
      req_addr  = ad + 16'(i); // whole text or float field in one burst
      req_wdata = wd;
    end
    @(posedge sys_clk);
    #1;
    req_valid = 1'b0;
    req_addr  = ~req_addr;  // released address and data lines never repeat the last value
    req_wdata = ~req_wdata;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask : xfer
endmodule : pscfg_master

// [verification/tb_top.sv]
// self-checking bench for the pressure transmitter config register bank
`timescale 1ns/1ps
module tb_top;
  import pscfg_pkg::*;
  localparam int           SCYC = 8;
  localparam logic [127:0] SER  = 128'h41424344454647484950515253545556; // arbitrary
  localparam logic [15:0]  FW   = 16'h0203;                              // arbitrary
  localparam logic [127:0] NAME = 128'h6162636465666768696A6B6C6D6E6F70; // arbitrary
  localparam logic signed [15:0] PAV [4] = '{-16'sd111, -16'sd110, 16'sd110, 16'sd111};
  typedef struct packed {logic dchk; logic nak; logic [15:0] data; logic zr;} pscfg_exp_s;
  logic             sys_clk, reset, range_sel_bit0, range_sel_bit1, response_sel_bit0;
  logic             response_sel_bit1, unit_sel_bit0, unit_sel_bit1, backlight_off_sw;
  logic             output_span_sw, settings_source_sw, unused_switch, nv_backlight_off;
  logic             nv_output_span, proto_bacnet, tool_addr_wr, req_valid, req_write;
  logic             meas_valid, resp_valid, resp_nak, backlight_on, output_span_alt;
  logic             under_range, overload, two_stop_bits, zero_req, eu, eo;
  logic [1:0]       nv_range, nv_response, nv_unit, range_code, unit_code, parity_mode;
  logic [7:0]       addr_switches, tool_addr_data, req_func, node_address;
  logic [15:0]      req_addr, req_wdata, resp_data;
  logic [12:0]      filter_time_ms;
  logic [2:0]       baud_index;
  logic [4:0][31:0] meas_float, sf;
  logic [4:0][15:0] meas_int, si;
  logic [31:0]      rng;
  int               n_mismatch, checks, cyc;
  pscfg_exp_s       ex;
  pscfg_exp_s       expq[$];

  pscfg_regs #(.SAMPLE_CYC(SCYC), .SERIAL_TEXT(SER), .FW_VERSION(FW), .SENSOR_NAME(NAME))
    i_pscfg_regs (.sys_clk, .reset, .range_sel_bit0, .range_sel_bit1, .response_sel_bit0,
    .response_sel_bit1, .unit_sel_bit0, .unit_sel_bit1, .backlight_off_sw, .output_span_sw,
    .settings_source_sw, .unused_switch, .addr_switches, .nv_range, .nv_response, .nv_unit,
    .nv_backlight_off, .nv_output_span, .proto_bacnet, .tool_addr_wr, .tool_addr_data,
    .req_valid, .req_write, .req_func, .req_addr, .req_wdata, .resp_valid, .resp_nak,
    .resp_data, .meas_valid, .meas_float, .meas_int, .range_code, .filter_time_ms, .unit_code,
    .backlight_on, .output_span_alt, .under_range, .overload, .node_address, .baud_index,
    .parity_mode, .two_stop_bits, .zero_req);
  pscfg_master i_pscfg_master (.sys_clk, .resp_valid, .req_valid, .req_write, .req_func,
    .req_addr, .req_wdata);

  // 100 MHz clock
  initial sys_clk = 1'b0;
  always #5 sys_clk = ~sys_clk;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs

  // expected read word for a mapped address, from the bench's own copies
  function automatic logic [15:0] expw(input logic [15:0] a);
    int i;
    i = int'(a - OFS_FLOAT) >> 1;
    if (a < 16'h0008) return SER[127 - 16 * int'(a) -: 16];
    if (a == OFS_FIRMWARE) return FW;
    if (a >= OFS_SENSOR_NAME && a < 16'h0011) return NAME[127 - 16 * (int'(a) - 9) -: 16];
    if (a == OFS_STATUS) return {12'h000, addr_switches != 8'h00, settings_source_sw, eo, eu};
    if (a >= OFS_FLOAT && a < OFS_FLOAT + 16'h000A) return a[0] ? sf[i][31:16] : sf[i][15:0];
    if (a >= OFS_INT && a < OFS_INT + 16'h0005) return si[a - OFS_INT];
    return 16'h0000;
  endfunction : expw

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  // reads: note expected words, then let the master send the burst
  task automatic rd(input logic [7:0] fn, input logic [15:0] ad, input int n, input logic nk);
    for (int i = 0; i < n; i++) begin
      expq.push_back('{1'b1, nk, nk ? 16'h0000 : expw(ad + 16'(i)), 1'b0});
    end
    i_pscfg_master.xfer(1'b0, fn, ad, 16'h0000, n);
  endtask : rd

  task automatic wr(input logic [15:0] ad, input logic [15:0] wd, input logic nk);
    expq.push_back('{1'b0, nk, 16'h0000, !nk && ad == OFS_MANUAL_ZERO});
    i_pscfg_master.xfer(1'b1, FC_WRITE_SINGLE, ad, wd, 1);
  endtask : wr

  task automatic setsw(input logic [9:0] v, input logic [7:0] a);
    {unused_switch, settings_source_sw, output_span_sw, backlight_off_sw, unit_sel_bit1,
     unit_sel_bit0, response_sel_bit1, response_sel_bit0, range_sel_bit1, range_sel_bit0} = v;
    addr_switches = a;
  endtask : setsw

  task automatic settle;
    repeat (10 * SCYC) @(posedge sys_clk);
    #1;
  endtask : settle

  task automatic cfg(input logic [1:0] r, input logic [1:0] t, input logic [1:0] u,
                     input logic bo, input logic sp);
    chk("range_code", range_code, r);
    chk("filter_time_ms", filter_time_ms, FILTER_MS[t]);
    chk("unit_code", unit_code, u);
    chk("backlight_on", backlight_on, bo);
    chk("output_span_alt", output_span_alt, sp);
  endtask : cfg

  // new sample with a chosen Pa value; lines change afterwards to test the snapshot
  task automatic meas(input logic [15:0] pa);
    for (int k = 0; k < 5; k++) begin
      rng = xs(rng);
      meas_float[k] = rng;
      meas_int[k] = rng[15:0];
    end
    meas_int[2] = pa;
    sf = meas_float;
    si = meas_int;
    meas_valid = 1'b1;
    @(posedge sys_clk);
    #1;
    meas_valid = 1'b0;
    meas_float = ~meas_float;
    meas_int = ~meas_int;
    @(posedge sys_clk);
    #1;
  endtask : meas

  // response monitor: oldest note against each response
  always @(posedge sys_clk) begin
    if (resp_valid === 1'b1) begin
      if (expq.size() == 0) chk("spare response", 32'h1, 32'h0);
      else begin
        ex = expq.pop_front();
        chk("resp_nak", resp_nak, ex.nak);
        if (ex.dchk) chk("resp_data", resp_data, ex.data);
        chk("zero_req", zero_req, ex.zr);
      end
    end
  end

  // hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end

  initial begin
    rng = 32'h3310;
    {nv_range, nv_response, nv_unit, nv_backlight_off, nv_output_span} = 8'h00;
    {proto_bacnet, tool_addr_wr, tool_addr_data, meas_valid, eu, eo} = 13'h0000;
    meas_float = '0;
    meas_int = '0;
    setsw(10'h000, 8'h00);
    reset = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    reset = 1'b0;
    cfg(2'h0, 2'h0, 2'h0, 1'b1, 1'b0);
    chk("node_address", node_address, NODE_ADDR_RST);
    chk("framing", {baud_index, parity_mode, two_stop_bits}, 6'h02);
    // every switch code, tenth switch random
    for (int k = 0; k < 4; k++) begin
      rng = xs(rng);
      setsw({rng[0], 1'b0, k[0], k[1], k[1:0], k[1:0], k[1:0]}, 8'h00);
      repeat (3) @(posedge sys_clk);
      #1;
      if (k > 0) chk("debounce hold", range_code, 32'(k - 1));
      settle();
      cfg(k[1:0], k[1:0], k[1:0], !k[1], k[0]);
    end
    // stored settings override the switch bank
    {nv_range, nv_response, nv_unit, nv_backlight_off, nv_output_span} = 8'hB7;
    setsw(10'h1FF, 8'h00);
    settle();
    cfg(2'h2, 2'h3, 2'h1, 1'b0, 1'b1);
    rd(FC_READ_INPUT, OFS_STATUS, 1, 1'b0);
    setsw(10'h000, 8'h00);
    settle();
    rd(FC_READ_HOLD, OFS_SERIAL, 8, 1'b0);
    rd(FC_READ_INPUT, OFS_SERIAL, 8, 1'b0);
    rd(FC_READ_HOLD, OFS_FIRMWARE, 1, 1'b0);
    rd(FC_READ_INPUT, OFS_SENSOR_NAME, 8, 1'b0);
    rd(8'h05, OFS_FIRMWARE, 1, 1'b1);
    rd(FC_READ_HOLD, 16'h0011, 1, 1'b1);
    // range flags at the 5 % boundaries of the widest range
    for (int k = 0; k < 4; k++) begin
      meas(PAV[k]);
      eu = (k == 0);
      eo = (k == 3);
      chk("under_range", under_range, eu);
      chk("overload", overload, eo);
    end
    rd(FC_READ_HOLD, OFS_STATUS, 1, 1'b0);
    rd(FC_READ_INPUT, OFS_FLOAT, 10, 1'b0);
    rd(FC_READ_HOLD, OFS_INT, 5, 1'b0);
    // address and framing writes, Modbus limits
    wr(OFS_NODE_ADDR, 16'h0005, 1'b0);
    chk("node_address", node_address, 8'h05);
    wr(OFS_NODE_ADDR, 16'h00F8, 1'b1);
    wr(OFS_NODE_ADDR, 16'h0000, 1'b1);
    wr(OFS_FRAMING, 16'h0031, 1'b0);
    chk("framing", {baud_index, parity_mode, two_stop_bits}, 6'h0D);
    wr(OFS_FRAMING, 16'h0003, 1'b1);
    // BACnet limits
    proto_bacnet = 1'b1;
    wr(OFS_NODE_ADDR, 16'h0080, 1'b1);
    wr(OFS_NODE_ADDR, 16'h0000, 1'b0);
    chk("node_address", node_address, 8'h00);
    wr(OFS_FRAMING, 16'h0004, 1'b0);
    chk("framing", {baud_index, parity_mode, two_stop_bits}, 6'h20);
    wr(OFS_FRAMING, 16'h000C, 1'b1);
    // configuration tool writes the stored address
    tool_addr_data = 8'h21;
    tool_addr_wr = 1'b1;
    @(posedge sys_clk);
    #1;
    tool_addr_wr = 1'b0;
    chk("node_address", node_address, 8'h21);
    setsw(10'h000, 8'h03);
    settle();
    chk("node_address", node_address, 8'h03);
    wr(OFS_NODE_ADDR, 16'h0007, 1'b1);
    chk("node_address", node_address, 8'h03);
    wr(OFS_MANUAL_ZERO, 16'h0000, 1'b0);
    chk("pending responses", expq.size(), 32'h0);
    stop_test();
  end
endmodule : tb_top
